/* File: verilog/output_shutdown_unit.sv */
// Output shutdown unit: two groups gating the pwm_timer channel outputs
`timescale 1ns/1ps
module output_shutdown_unit
	import shutdown_pkg::*;
(
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// Register port
	input  wire logic [3:0]              addr,
	input  wire logic [7:0]              wdata,
	input  wire logic                    wr,
	input  wire logic                    rd,
	output logic      [7:0]              rdata,
	// Trip inputs per group, from pins
	input  wire logic                    external_trip_input_a,
	input  wire logic                    external_trip_input_b,
	// Timer and comparator disable requests, per group
	input  wire logic [1:0]              pwm_timer_disable_req,
	input  wire logic [1:0]              fast_comparator_req,
	// Oscillation stop from clock monitor
	input  wire logic                    osc_stop,
	// Timer outputs in
	input  wire logic [3:0]              timer_a_in,
	input  wire logic [3:0]              timer_b_in,
	// Pins out, with output enables
	output logic      [3:0]              timer_output_a,
	output logic      [3:0]              timer_output_a_oe,
	output logic      [3:0]              timer_output_b,
	output logic      [3:0]              timer_output_b_oe,
	// Interrupt
	output logic                         irq
);
`include "shutdown_consts.svh"

	logic [3:0]  ctrl_a;
	logic [3:0]  ctrl_b;
	logic [3:0]  chgrp;
	logic [7:0]  int_mask;
	logic [7:0]  int_stat;
	logic [1:0]  trip_s1;
	logic [1:0]  trip_s2;
	logic [1:0]  trip_s3;
	logic        osc_s1;
	logic        osc_s2;
	logic [1:0]  trip_rise;
	logic [1:0]  sw_pulse;
	logic [1:0]  clr_pulse;
	flags_t      flags_a;
	flags_t      flags_b;
	logic        stop_a;
	logic        stop_b;
	logic [7:0]  next_int_stat;
	logic [3:0]  ch_stop;
	flags_t      flags_a_q;
	flags_t      flags_b_q;
	logic        req_ev_a;
	logic        req_ev_b;

	function automatic logic wr_hit(input logic [3:0] a);
		wr_hit = wr && (addr == a);
	endfunction

	// Request source: enabled and either timer or comparator asks
	function automatic logic req_hit(input logic en, input logic tmr, input logic cmp);
		req_hit = en && (tmr || cmp);
	endfunction

	// Trip pins pass two flops; third stage for edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			trip_s1 <= 2'h0;
			trip_s2 <= 2'h0;
			trip_s3 <= 2'h0;
		end else begin
			trip_s1 <= {external_trip_input_b, external_trip_input_a};
			trip_s2 <= trip_s1;
			trip_s3 <= trip_s2;
		end
	end

	// Oscillation stop level passes two flops
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc_s1 <= 1'b0;
			osc_s2 <= 1'b0;
		end else begin
			osc_s1 <= osc_stop;
			osc_s2 <= osc_s1;
		end
	end

	assign trip_rise[0] = ctrl_a[`SD_CTRL_TRIP_EN] && trip_s2[0] && !trip_s3[0];
	assign trip_rise[1] = ctrl_b[`SD_CTRL_TRIP_EN] && trip_s2[1] && !trip_s3[1];

	// Software stop and clear pulses
	assign sw_pulse[0]  = wr_hit(`SD_OFF_CTRL_A) && wdata[`SD_CTRL_SW_STOP];
	assign sw_pulse[1]  = wr_hit(`SD_OFF_CTRL_B) && wdata[`SD_CTRL_SW_STOP];
	assign clr_pulse[0] = wr_hit(`SD_OFF_CLEAR) && wdata[`SD_CLR_A];
	assign clr_pulse[1] = wr_hit(`SD_OFF_CLEAR) && wdata[`SD_CLR_B];

	// Control register of group A; software stop bit is not stored
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_a <= `SD_CTRL_RST;
		end else if (wr_hit(`SD_OFF_CTRL_A)) begin
			ctrl_a <= {1'b0, wdata[2:0]};
		end
	end

	// Control register of group B
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_b <= `SD_CTRL_RST;
		end else if (wr_hit(`SD_OFF_CTRL_B)) begin
			ctrl_b <= {1'b0, wdata[2:0]};
		end
	end

	// Channel to group map
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chgrp <= `SD_CHGRP_RST;
		end else if (wr_hit(`SD_OFF_CHGRP)) begin
			chgrp <= wdata[3:0];
		end
	end

	// Interrupt mask
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_mask <= `SD_MASK_RST;
		end else if (wr_hit(`SD_OFF_INT_MASK)) begin
			int_mask <= wdata;
		end
	end

	// Request events per group
	assign req_ev_a = req_hit(ctrl_a[`SD_CTRL_REQ_EN], pwm_timer_disable_req[0],
	                          fast_comparator_req[0]);
	assign req_ev_b = req_hit(ctrl_b[`SD_CTRL_REQ_EN], pwm_timer_disable_req[1],
	                          fast_comparator_req[1]);

	// Group A: all four sources
	shutdown_group u_group_a (
		.clk       (clk),
		.resetn    (resetn),
		.trip_rise (trip_rise[0]),
		.req_ev    (req_ev_a),
		.osc_ev    (ctrl_a[`SD_CTRL_OSC_EN] && osc_s2),
		.sw_ev     (sw_pulse[0]),
		.clear_all (clr_pulse[0]),
		.flags     (flags_a),
		.stopped   (stop_a)
	);

	// Group B, independent of A
	shutdown_group u_group_b (
		.clk       (clk),
		.resetn    (resetn),
		.trip_rise (trip_rise[1]),
		.req_ev    (req_ev_b),
		.osc_ev    (ctrl_b[`SD_CTRL_OSC_EN] && osc_s2),
		.sw_ev     (sw_pulse[1]),
		.clear_all (clr_pulse[1]),
		.flags     (flags_b),
		.stopped   (stop_b)
	);

	// Channel stop: each channel follows its selected group only
	always_comb begin
		for (int i = 0; i < `SD_NUM_CH; i++) begin
			ch_stop[i] = chgrp[i] ? stop_b : stop_a;
		end
	end

	// Output pin values registered
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_output_a <= 4'h0;
			timer_output_b <= 4'h0;
		end else begin
			timer_output_a <= timer_a_in;
			timer_output_b <= timer_b_in;
		end
	end

	// Output enables registered; low means high impedance
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_output_a_oe <= 4'h0;
			timer_output_b_oe <= 4'h0;
		end else begin
			timer_output_a_oe <= ~ch_stop;
			timer_output_b_oe <= ~ch_stop;
		end
	end

	// Interrupt status: {group B, group A}, write one to clear
	always_comb begin
		next_int_stat = int_stat;
		if (wr_hit(`SD_OFF_FLAG_A)) next_int_stat[3:0] = int_stat[3:0] & ~wdata[3:0];
		if (wr_hit(`SD_OFF_FLAG_B)) next_int_stat[7:4] = int_stat[7:4] & ~wdata[3:0];
		// Sources set on the flag's rising edge; set wins over clear
		next_int_stat = next_int_stat | {flags_b & ~flags_b_q, flags_a & ~flags_a_q};
	end

	// Previous flags, for rising edge detection
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_a_q <= `SD_FLAG_RST;
			flags_b_q <= `SD_FLAG_RST;
		end else begin
			flags_a_q <= flags_a;
			flags_b_q <= flags_b;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_stat <= `SD_MASK_RST;
		end else begin
			int_stat <= next_int_stat;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_int_stat & int_mask);
		end
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else if (rd) begin
			case (addr)
				`SD_OFF_CTRL_A:   rdata <= {4'h0, ctrl_a};
				`SD_OFF_CTRL_B:   rdata <= {4'h0, ctrl_b};
				`SD_OFF_FLAG_A:   rdata <= {int_stat[3:0], flags_a};
				`SD_OFF_FLAG_B:   rdata <= {int_stat[7:4], flags_b};
				`SD_OFF_CHGRP:    rdata <= {4'h0, chgrp};
				`SD_OFF_INT_MASK: rdata <= int_mask;
				`SD_OFF_PINS:     rdata <= {2'h0, stop_b, stop_a, trip_s2, osc_s2, 1'b0};
				default:          rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end
endmodule

/* File: pkg/shutdown_consts.svh */
// Register offsets, field positions, reset values and sizes of the output shutdown unit
`ifndef SHUTDOWN_CONSTS_SVH
`define SHUTDOWN_CONSTS_SVH

`define SD_NUM_CH        4
`define SD_ADDR_W        4
`define SD_OFF_CTRL_A    4'h0
`define SD_OFF_CTRL_B    4'h1
`define SD_OFF_FLAG_A    4'h2
`define SD_OFF_FLAG_B    4'h3
`define SD_OFF_CHGRP     4'h4
`define SD_OFF_INT_MASK  4'h5
`define SD_OFF_PINS      4'h6
`define SD_OFF_CLEAR     4'h7
// Control fields
`define SD_CTRL_TRIP_EN  0
`define SD_CTRL_REQ_EN   1
`define SD_CTRL_OSC_EN   2
`define SD_CTRL_SW_STOP  3
// Flag fields
`define SD_FLG_TRIP      0
`define SD_FLG_REQ       1
`define SD_FLG_OSC       2
`define SD_FLG_SW        3
// Clear register fields
`define SD_CLR_A         0
`define SD_CLR_B         1
// Reset values
`define SD_CTRL_RST      4'h0
`define SD_FLAG_RST      4'h0
`define SD_CHGRP_RST     4'h0
`define SD_MASK_RST      8'h00

`endif

/* File: pkg/shutdown_pkg.sv */
// Types shared by the output shutdown unit
package shutdown_pkg;
	typedef logic [3:0] flags_t;
	typedef enum logic [1:0] {
		GRP_RUN  = 2'b01,
		GRP_STOP = 2'b10
	} grp_state_e;
endpackage

/* File: verilog/shutdown_group.sv */
// One shutdown group: sticky detection flags and stop state
`timescale 1ns/1ps
module shutdown_group
	import shutdown_pkg::*;
(
	// Clock and reset
	input  wire logic   clk,
	input  wire logic   resetn,
	// Enabled sources: trip and software stop are one-cycle events, request and oscillation stop are levels
	input  wire logic   trip_rise,
	input  wire logic   req_ev,
	input  wire logic   osc_ev,
	input  wire logic   sw_ev,
	// Clear all flags of this group
	input  wire logic   clear_all,
	// Flags and stop state
	output flags_t      flags,
	output logic        stopped
);
`include "shutdown_consts.svh"

	flags_t     set_vec;
	flags_t     next_flags;
	grp_state_e state;

	always_comb begin
		set_vec = `SD_FLAG_RST;
		set_vec[`SD_FLG_TRIP] = trip_rise;
		set_vec[`SD_FLG_REQ]  = req_ev;
		set_vec[`SD_FLG_OSC]  = osc_ev;
		set_vec[`SD_FLG_SW]   = sw_ev;
	end

	// Set wins over a clear in the same cycle
	always_comb begin
		next_flags = (clear_all ? `SD_FLAG_RST : flags) | set_vec;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags <= `SD_FLAG_RST;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= GRP_RUN;
		end else begin
			case (state)
				GRP_RUN:  if (|next_flags) state <= GRP_STOP;
				GRP_STOP: if (~|next_flags) state <= GRP_RUN;
				default:  state <= GRP_RUN;
			endcase
		end
	end

	assign stopped = (state == GRP_STOP);
endmodule

/* File: test/output_shutdown_unit_checker.sv */
// Port-level assertions for the output shutdown unit
`timescale 1ns/1ps
module output_shutdown_unit_checker (
	// Clock, reset, register port
	input wire logic       clk, resetn, wr, rd,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata, rdata,
	// Sources
	input wire logic       external_trip_input_a, osc_stop,
	input wire logic [1:0] pwm_timer_disable_req, fast_comparator_req,
	// Pins and interrupt
	input wire logic [3:0] timer_a_in, timer_output_a, timer_output_a_oe, timer_output_b_oe,
	input wire logic [3:0] timer_b_in, timer_output_b,
	input wire logic       irq
);
	logic [2:0] en_a, en_b;
	logic [3:0] grp;
	logic [7:0] mask;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Shadow of enables, group map and mask
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) {en_a, en_b, grp, mask} <= '0;
		else if (wr) case (addr)
			4'h0: en_a <= wdata[2:0];
			4'h1: en_b <= wdata[2:0];
			4'h4: grp <= wdata[3:0];
			4'h5: mask <= wdata;
			default: ;
		endcase
	end
	a_pair_same_oe: assert property (timer_output_a_oe == timer_output_b_oe)
		else $error("pair enables differ");
	a_pin_copy: assert property ($past(resetn) |-> timer_output_a == $past(timer_a_in))
		else $error("pin value not copied");
	a_pin_copy_b: assert property ($past(resetn) |-> timer_output_b == $past(timer_b_in))
		else $error("pin b value not copied");
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not idle");
	a_trip_stops: assert property ($rose(external_trip_input_a) && en_a[0]
		|-> ##[3:8] (timer_output_a_oe & ~grp) == 4'h0) else $error("trip ignored");
	a_req_stops_a: assert property (en_a[1] && (pwm_timer_disable_req[0]
		|| fast_comparator_req[0]) |-> ##3 (timer_output_a_oe & ~grp) == 4'h0)
		else $error("request ignored in A");
	a_req_stops_b: assert property (en_b[1] && (pwm_timer_disable_req[1]
		|| fast_comparator_req[1]) |-> ##3 (timer_output_a_oe & grp) == 4'h0)
		else $error("request ignored in B");
	a_osc_stops: assert property (en_a[2] && osc_stop
		|-> ##[4:6] (timer_output_a_oe & ~grp) == 4'h0) else $error("osc stop ignored");
	a_irq_masked: assert property (mask == 8'h00 |=> !irq)
		else $error("masked interrupt raised");
	c_irq: cover property ($rose(irq));
	c_all_off: cover property (timer_output_a_oe == 4'h0);
	c_release: cover property ($rose(timer_output_a_oe[0]));
endmodule
bind output_shutdown_unit output_shutdown_unit_checker chk_u (.*);

/* File: test/pwm_timer_model.sv */
// Timer channel model: changing outputs and disable requests
`timescale 1ns/1ps
module pwm_timer_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [1:0] stop_cmd,
	output logic      [3:0] out_a,
	output logic      [3:0] out_b,
	output logic      [1:0] disable_req
);
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) {out_a, out_b, disable_req} <= '0;
		else begin
			out_a <= out_a + 4'h5;
			out_b <= ~out_a;
			disable_req <= stop_cmd;
		end
	end
endmodule

/* File: test/tb_top.sv */
// Testbench for the output shutdown unit
`timescale 1ns/1ps
module tb_top;
	logic       clk = 0, resetn = 0, wr = 0, rd = 0, trip = 0, tripb = 0, osc = 0, irq;
	logic [3:0] addr = 4'h0, ta, tb, oa, ob, oea, oeb;
	logic [7:0] wdata = 8'h00, rdata;
	logic [1:0] cmd = 2'h0, dreq, creq = 2'h0;
	int         num_errors = 0, cmp_count = 0;
	always #25 clk = ~clk;
	pwm_timer_model tm_u (.clk(clk), .resetn(resetn), .stop_cmd(cmd), .out_a(ta),
		.out_b(tb), .disable_req(dreq));
	output_shutdown_unit dut_u (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .external_trip_input_a(trip),
		.external_trip_input_b(tripb), .pwm_timer_disable_req(dreq), .fast_comparator_req(creq),
		.osc_stop(osc), .timer_a_in(ta), .timer_b_in(tb), .timer_output_a(oa),
		.timer_output_a_oe(oea), .timer_output_b(ob), .timer_output_b_oe(oeb), .irq(irq));
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wreg(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rchk(logic [3:0] a, logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 chk("rdata", rdata, exp);
	endtask
	task automatic oe_is(logic [3:0] exp);
		repeat (20) begin
			@(posedge clk);
			if (oea === exp) break;
		end
		chk("oe", {4'h0, oea}, {4'h0, exp});
	endtask
	task automatic clr;
		wreg(4'h2, 8'h0F);
		wreg(4'h3, 8'h0F);
		wreg(4'h7, 8'h03);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		give_verdict;
	end
	initial begin
		repeat (10) @(posedge clk);
		resetn <= 1;
		oe_is(4'hF);
		rchk(4'hF, 8'h00);
		wreg(4'h4, 8'h0C);
		wreg(4'h5, 8'h0F);
		wreg(4'h0, 8'h01);
		trip <= 1;
		oe_is(4'hC);
		rchk(4'h6, 8'h14);
		trip <= 0;
		repeat (8) @(posedge clk);
		oe_is(4'hC);
		rchk(4'h2, 8'h11);
		chk("irq", {7'h0, irq}, 8'h01);
		clr;
		oe_is(4'hF);
		chk("irq", {7'h0, irq}, 8'h00);
		$display("trip test done");
		wreg(4'h1, 8'h01);
		tripb <= 1;
		oe_is(4'h3);
		tripb <= 0;
		rchk(4'h3, 8'h11);
		clr;
		oe_is(4'hF);
		$display("trip b test done");
		wreg(4'h1, 8'h02);
		cmd <= 2'h2;
		oe_is(4'h3);
		rchk(4'h3, 8'h22);
		chk("irq", {7'h0, irq}, 8'h00);
		cmd <= 2'h0;
		wreg(4'h0, 8'h02);
		creq <= 2'h1;
		oe_is(4'h0);
		creq <= 2'h0;
		rchk(4'h2, 8'h22);
		wreg(4'h7, 8'h02);
		oe_is(4'hC);
		clr;
		oe_is(4'hF);
		$display("request test done");
		wreg(4'h0, 8'h04);
		wreg(4'h1, 8'h04);
		osc <= 1;
		oe_is(4'h0);
		osc <= 0;
		rchk(4'h2, 8'h44);
		clr;
		oe_is(4'hF);
		$display("osc test done");
		wreg(4'h0, 8'h08);
		oe_is(4'hC);
		rchk(4'h2, 8'h88);
		rchk(4'h0, 8'h00);
		clr;
		oe_is(4'hF);
		$display("software stop test done");
		give_verdict;
	end
endmodule
